/* rtl/cam_power_pkg.sv */
`default_nettype none
package cam_power_pkg;
	// Power states; Gray codes along off -> uninit -> on -> overtemp -> shutdown.
	typedef enum logic [2:0] {
		ST_OFF      = 3'h0,
		ST_UNINIT   = 3'h1,
		ST_ON       = 3'h3,
		ST_OVERTEMP = 3'h2,
		ST_SHUTDOWN = 3'h6
	} power_state_t;

	// Temperature threshold in degrees Celsius, as an unsigned code.
	localparam logic [7:0] TEMP_LIMIT_C = 8'h50;
	// Over-temperature countdown time and the clock rate.
	localparam int unsigned OVERTEMP_MS     = 10000;
	localparam int unsigned CLK_KHZ         = 50000;
	localparam longint unsigned OVERTEMP_CYC = longint'(OVERTEMP_MS) * longint'(CLK_KHZ);
	// Master clock periods that reset must cover during start-up.
	localparam int unsigned BOOT_MCLK_PERIODS = 5000;

	// Host-facing status carried out of the sequencer.
	typedef struct packed {
		logic shutdown_imminent;
		logic functions_on;
		logic interfaces_on;
	} power_status_t;
endpackage
`default_nettype wire

/* rtl/camera_power_state_sequencer.sv */
// Notes on behaviour
// - Exactly five power states: off, uninitialized, on, shutdown, over-temperature.
// - Only host actions move states, except automatic over-temperature entry and exit; supply loss also forces off, and off moves on to uninitialized unaided.
// - Off, with supplies absent, offers no camera function.
// - After power-up the device sits uninitialized until booted; host should boot it.
// - On state makes every function and interface available.
// - Shutdown offers nothing but accepts pin start-up or software wake.
// - Enter over-temperature when sensed temperature exceeds about 80 C.
// - On entry set the shutdown-imminent warning and start a 10 second countdown.
// - Cooling to 80 C or below before expiry clears the warning and returns to on.
// - Countdown expiry moves the device to shutdown automatically.
`default_nettype none
module camera_power_state_sequencer
	import cam_power_pkg::*;
#(
	parameter longint unsigned OVERTEMP_CYCLES = OVERTEMP_CYC,
	parameter int unsigned     BOOT_PERIODS    = BOOT_MCLK_PERIODS
) (
	// System clock and reset.
	input  wire logic          clk_sys_in,
	input  wire logic          reset_n_in,
	// Supply and host pins.
	input  wire logic          supply_good_in,
	input  wire logic          power_down_n_in,
	input  wire logic          cam_reset_n_in,
	input  wire logic          master_clk_tick_in,
	// Software power commands and sensed temperature.
	input  wire logic          sw_wake_in,
	input  wire logic          sw_sleep_in,
	input  wire logic [7:0]    temp_c_in,
	// State and status.
	output logic [2:0]         power_state_out,
	output power_status_t      status_out
);
	localparam int CW = $clog2(OVERTEMP_CYCLES + 1);
	localparam int BW = $clog2(BOOT_PERIODS + 2);

	logic         rst_meta_ff;
	logic         rst_sync_ff;
	power_state_t state_ff;
	power_state_t nxt_state;
	logic [CW-1:0] count_ff;
	logic [BW-1:0] boot_cnt_ff;
	logic         hot;
	logic         boot_done;
	power_status_t nxt_status;
	power_status_t status_ff;

	// Reset release through two flops so all logic leaves reset together.
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	assign hot = temp_c_in > TEMP_LIMIT_C;

	// Count master clock periods while held in reset with power-down released.
	// The count saturates so a long hold cannot wrap back below the threshold.
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			boot_cnt_ff <= '0;
		end else if (!power_down_n_in || !supply_good_in) begin
			boot_cnt_ff <= '0;
		end else if (cam_reset_n_in) begin
			boot_cnt_ff <= '0;
		end else if (!cam_reset_n_in && master_clk_tick_in &&
			boot_cnt_ff <= BW'(BOOT_PERIODS)) begin
			boot_cnt_ff <= boot_cnt_ff + BW'(1);
		end
	end

	// Boot strobes for the one cycle in which reset is released after a long enough hold.
	// Release also spends the count, so pins left high cannot wake shutdown again.
	assign boot_done = cam_reset_n_in && power_down_n_in &&
		(boot_cnt_ff > BW'(BOOT_PERIODS));

	// Next power state.
	always_comb begin
		nxt_state = state_ff;
		if (!supply_good_in) begin
			nxt_state = ST_OFF;
		end else begin
			unique case (state_ff)
				ST_OFF: begin
					nxt_state = ST_UNINIT;
				end
				ST_UNINIT: begin
					if (boot_done) begin
						nxt_state = ST_ON;
					end
				end
				ST_ON: begin
					if (hot) begin
						nxt_state = ST_OVERTEMP;
					end else if (sw_sleep_in || !power_down_n_in) begin
						nxt_state = ST_SHUTDOWN;
					end
				end
				ST_OVERTEMP: begin
					if (!hot) begin
						nxt_state = ST_ON;
					end else if (count_ff == '0) begin
						nxt_state = ST_SHUTDOWN;
					end
				end
				ST_SHUTDOWN: begin
					if (boot_done || sw_wake_in) begin
						nxt_state = ST_ON;
					end
				end
				default: begin
					nxt_state = ST_UNINIT;
				end
			endcase
		end
	end

	// State register; an illegal code falls back to uninitialized.
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			state_ff <= ST_OFF;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Countdown loaded on entry to over-temperature, running while there.
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			count_ff <= '0;
		end else if (state_ff != ST_OVERTEMP) begin
			count_ff <= CW'(OVERTEMP_CYCLES - 1);
		end else if (count_ff != '0) begin
			count_ff <= count_ff - CW'(1);
		end
	end

	// Status flags follow the next state so they change with it.
	always_comb begin
		nxt_status.shutdown_imminent = (nxt_state == ST_OVERTEMP);
		nxt_status.functions_on      = (nxt_state == ST_ON) ||
			(nxt_state == ST_OVERTEMP);
		nxt_status.interfaces_on     = nxt_status.functions_on;
	end

	// Status is registered so the host never sees a combinational glitch.
	always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
		if (!rst_sync_ff) begin
			status_ff <= '0;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Outputs come straight from the state and status flops.
	assign power_state_out = state_ff;
	assign status_out      = status_ff;

	// Warning stands exactly while in over-temperature.
	warn_tracks_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		status_ff.shutdown_imminent == (state_ff == ST_OVERTEMP))
		else $error("warning bit does not track over-temperature");

	hot_entry_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(state_ff == ST_ON && hot && supply_good_in) |=> state_ff == ST_OVERTEMP)
		else $error("no over-temperature entry");

	cool_exit_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(state_ff == ST_OVERTEMP && !hot && supply_good_in) |=> state_ff == ST_ON)
		else $error("no return to on after cooling");

	expire_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(state_ff == ST_OVERTEMP && hot && supply_good_in && count_ff == '0)
		|=> state_ff == ST_SHUTDOWN)
		else $error("countdown expiry missed");

	countdown_run_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		($rose(state_ff == ST_OVERTEMP)) |-> count_ff == CW'(OVERTEMP_CYCLES - 1))
		else $error("countdown not loaded on entry");

	off_dead_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		!supply_good_in |=> state_ff == ST_OFF ##1 !status_ff.functions_on)
		else $error("functions alive without supply");

	on_funcs_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		state_ff == ST_ON |-> status_ff.functions_on && status_ff.interfaces_on)
		else $error("on state lacks functions");

	shut_stays_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(state_ff == ST_SHUTDOWN && supply_good_in && !boot_done && !sw_wake_in)
		|=> state_ff == ST_SHUTDOWN)
		else $error("shutdown left without host action");

	uninit_boot_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(state_ff == ST_UNINIT && $rose(state_ff == ST_UNINIT)) |-> !status_ff.functions_on)
		else $error("uninitialized device shows functions");

	// Host-driven moves, the boot strobe and the boot counter ceiling.
	sleep_entry_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(state_ff == ST_ON && !hot && supply_good_in && (sw_sleep_in || !power_down_n_in))
		|=> state_ff == ST_SHUTDOWN)
		else $error("host sleep request ignored");

	uninit_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		(state_ff == ST_UNINIT && supply_good_in && !boot_done) |=> state_ff == ST_UNINIT)
		else $error("uninitialized state left without boot");

	boot_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		boot_done |=> !boot_done)
		else $error("boot strobe held longer than one cycle");

	boot_sat_a: assert property (@(posedge clk_sys_in) disable iff (!rst_sync_ff)
		boot_cnt_ff <= BW'(BOOT_PERIODS + 1))
		else $error("boot counter ran past its ceiling");
endmodule
`default_nettype wire

/* test/camera_power_state_sequencer_tb.sv */
`default_nettype none
module camera_power_state_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import cam_power_pkg::*;
	typedef struct packed {
		logic [7:0] temp;
		logic       wake;
		logic       sleep;
		logic [2:0] st;
	} row_t;
	logic          clk_sys_in = 1'b0;
	logic          reset_n_in = 1'b0;
	logic          supply = 1'b1;
	logic          boot = 1'b0;
	logic          wake = 1'b0;
	logic          sleep = 1'b0;
	logic [7:0]    temp = 8'h20;
	logic          pd_n, rst_n, tick;
	logic [2:0]    state;
	power_status_t status;
	int            fail_count = 0;
	int            total_checks = 0;
	row_t rows [9] = '{'{8'h50, 1'b0, 1'b0, ST_ON}, '{8'h51, 1'b0, 1'b0, ST_OVERTEMP},
		'{8'h50, 1'b0, 1'b0, ST_ON}, '{8'h20, 1'b1, 1'b0, ST_ON},
		'{8'h20, 1'b0, 1'b1, ST_SHUTDOWN}, '{8'hFF, 1'b0, 1'b0, ST_SHUTDOWN},
		'{8'h20, 1'b1, 1'b0, ST_ON}, '{8'h51, 1'b0, 1'b1, ST_OVERTEMP},
		'{8'h20, 1'b0, 1'b0, ST_ON}};

	// Countdown and boot length are cut down so the run stays short.
	camera_power_state_sequencer #(.OVERTEMP_CYCLES(20), .BOOT_PERIODS(4)) dut_u (
		.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .supply_good_in(supply),
		.power_down_n_in(pd_n), .cam_reset_n_in(rst_n), .master_clk_tick_in(tick),
		.sw_wake_in(wake), .sw_sleep_in(sleep), .temp_c_in(temp),
		.power_state_out(state), .status_out(status));
	host_power_model #(.PERIODS(4)) host_u (.clk_in(clk_sys_in), .boot_in(boot),
		.power_down_n_out(pd_n), .cam_reset_n_out(rst_n), .tick_out(tick));

	// The clock toggles every half period.
	always #10 clk_sys_in = ~clk_sys_in;

	task automatic chk(input string nm, input logic [2:0] seen, input logic [2:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Steps just past the edge, so the design's updates have landed.
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask
	// The state must not move before the host releases reset.
	task automatic boot_up(input logic [2:0] from);
		int i;
		@(posedge clk_sys_in) boot <= 1'b1;
		for (i = 0; i < 40 && rst_n !== 1'b1; i++) step(1);
		if (i == 40) begin
			fail_count++;
			final_report();
		end
		chk("pre boot", state, from);
		step(1);
		chk("booted", state, ST_ON);
		chk("status on", status, 3'h3);
	endtask

	initial begin
		repeat (20) @(posedge clk_sys_in);
		reset_n_in <= 1'b1;
		step(4);
		chk("uninit", state, ST_UNINIT);
		boot_up(ST_UNINIT);
		foreach (rows[k]) begin
			@(posedge clk_sys_in);
			temp <= rows[k].temp;
			wake <= rows[k].wake;
			sleep <= rows[k].sleep;
			step(1);
			chk("row", state, rows[k].st);
			chk("warn", {2'h0, status.shutdown_imminent}, {2'h0, rows[k].st == ST_OVERTEMP});
		end
		// The countdown runs out while the camera stays hot.
		@(posedge clk_sys_in) temp <= 8'h90;
		step(20);
		chk("late hot", state, ST_OVERTEMP);
		step(1);
		chk("expired", state, ST_SHUTDOWN);
		chk("warn off", {2'h0, status.shutdown_imminent}, 3'h0);
		@(posedge clk_sys_in) temp <= 8'h20;
		boot <= 1'b0;
		step(4);
		chk("no funcs", {2'h0, status.functions_on}, 3'h0);
		boot_up(ST_SHUTDOWN);
		@(posedge clk_sys_in) boot <= 1'b0;
		step(3);
		chk("pin sleep", state, ST_SHUTDOWN);
		@(posedge clk_sys_in) supply <= 1'b0;
		step(1);
		chk("off", state, ST_OFF);
		chk("off stat", status, 3'h0);
		@(posedge clk_sys_in) supply <= 1'b1;
		step(1);
		chk("reup", state, ST_UNINIT);
		boot_up(ST_UNINIT);
		// A mid-run reset drops straight to off and comes back uninitialized.
		@(posedge clk_sys_in) reset_n_in <= 1'b0;
		step(1);
		chk("rst off", state, ST_OFF);
		chk("rst stat", status, 3'h0);
		@(posedge clk_sys_in) reset_n_in <= 1'b1;
		step(4);
		chk("rst uninit", state, ST_UNINIT);
		final_report();
	end
endmodule
`default_nettype wire

/* test/host_power_model.sv */
`default_nettype none
module host_power_model #(
	parameter int unsigned PERIODS = 4
) (
	// Host side.
	input  wire logic clk_in,
	input  wire logic boot_in,
	// Camera pins.
	output logic      power_down_n_out,
	output logic      cam_reset_n_out,
	output logic      tick_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned cnt;

	// Boot keeps reset low until more than PERIODS ticks have passed.
	// Dropping boot re-asserts reset and stops the clock to save power.
	always_ff @(posedge clk_in) begin
		power_down_n_out <= boot_in;
		if (!boot_in) begin
			cnt <= 0;
			tick_out <= 1'b0;
			cam_reset_n_out <= 1'b0;
		end else begin
			tick_out <= ~tick_out;
			if (cnt < PERIODS + 1) cnt <= cnt + (tick_out ? 1 : 0);
			else cam_reset_n_out <= 1'b1;
		end
	end
endmodule
`default_nettype wire
